// ==== rtl/sppm_top.v ====
// Byte-wide full-duplex serial port, master or slave, with software strobes.
// Assumes strobes are one-cycle pulses from logic on clk_sys; pins are asynchronous.
`timescale 1ns/100ps
`include "sppm_defs.vh"
module sppm_top (
	input wire clk_sys,
	input wire reset_n,
	input wire cr_wr,
	input wire [2:0] cr_rate,
	input wire cr_clock_idle_polarity,
	input wire cr_clock_sample_phase,
	input wire cr_master_select,
	input wire cr_spe,
	input wire cr_serial_irq_enable,
	input wire csr_wr,
	input wire csr_ssm,
	input wire csr_ssi,
	input wire csr_rd,
	input wire dr_wr,
	input wire [7:0] dr_wdata,
	input wire dr_rd,
	input wire cpu_irq_mask,
	output reg [7:0] rx_data_r,
	output reg transfer_done_flag_r,
	output reg mode_fault_flag_r,
	output reg overrun_flag_r,
	output reg write_collision_flag_r,
	output reg master_select_r,
	output reg serial_enable_r,
	output reg busy_r,
	output reg irq_req_r,
	input wire sck_in,
	output reg sck_out_r,
	output reg sck_oe_r,
	input wire mosi_in,
	output reg mosi_out_r,
	output reg mosi_oe_r,
	input wire miso_in,
	output reg miso_out_r,
	output reg miso_oe_r,
	input wire ss_n_in
);
	reg [2:0] clock_rate_select_r;
	reg clock_idle_polarity_r;
	reg clock_sample_phase_r;
	reg serial_irq_enable_r;
	reg sel_sw_manage_r;
	reg sel_sw_level_r;
	reg csr_written_r;
	reg done_arm_r;
	reg mode_fault_flag_arm_r;
	reg write_collision_flag_arm_r;
	reg ovr_pend_r;
	reg [7:0] shift_r;
	reg samp_r;
	reg [3:0] edge_cnt_r;
	reg push_valid_r;
	reg [7:0] push_data_r;
	reg [2:0] sck_sync_r;
	reg [1:0] mosi_sync_r;
	reg [1:0] miso_sync_r;
	reg [1:0] ss_sync_r;
	wire sck_s;
	wire sck_prev;
	wire ss_int;
	wire in_bit;
	wire tick;
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [7:0] fifo_out_data;
	wire fifo_pop;
	wire fifo_flush;
	wire is_master;
	wire slave_sel;
	wire slave_edge;
	wire ev;
	wire lead;
	wire sample_edge;
	wire last_edge;
	wire fault;
	wire done_clear;
	wire wr_ok;
	wire wr_collide;
	wire [7:0] rx_byte;

	// Two-stage synchronisers for every pin input; sck keeps a third stage for edges.
	always @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sck_sync_r <= 3'h0;
			mosi_sync_r <= 2'h0;
			miso_sync_r <= 2'h0;
			ss_sync_r <= 2'h3;
		end
		else
		begin
			sck_sync_r <= {sck_sync_r[1:0], sck_in}; // [R6]
			mosi_sync_r <= {mosi_sync_r[0], mosi_in};
			miso_sync_r <= {miso_sync_r[0], miso_in};
			ss_sync_r <= {ss_sync_r[0], ss_n_in};
		end
	end

	// Present and previous synchronised clock levels feed the slave edge detector.
	assign sck_s = sck_sync_r[1];
	assign sck_prev = sck_sync_r[2];

	// Internal select comes from the level bit under software control, else the pin.
	assign ss_int = sel_sw_manage_r ? sel_sw_level_r : ss_sync_r[1]; // [R7] [R8]
	assign is_master = master_select_r & serial_enable_r;
	assign slave_sel = serial_enable_r & ~master_select_r & ~ss_int;
	assign fault = is_master & ~ss_int; // [R9] [R23]
	assign in_bit = master_select_r ? miso_sync_r[1] : mosi_sync_r[1]; // [R2]

	// Slave edges come only from the master's clock while selected.
	assign slave_edge = slave_sel & (sck_s != sck_prev); // [R6] [R17]
	assign ev = is_master ? (tick & busy_r) : slave_edge; // [R1]
	// Even edge counts are leading edges; the phase bit picks which edges sample.
	assign lead = ~edge_cnt_r[0];
	assign sample_edge = clock_sample_phase_r ? ~lead : lead;
	assign last_edge = (edge_cnt_r == `SPPM_EDGE_LAST);
	assign rx_byte = {shift_r[6:0], clock_sample_phase_r ? in_bit : samp_r};

	// A data write is refused while a byte is pending and its clear is unarmed, a transfer runs or, for a master, the queue is full.
	assign wr_ok = serial_enable_r & ~busy_r & (~transfer_done_flag_r | done_arm_r) &
		(master_select_r ? fifo_in_ready : (clock_sample_phase_r | ss_int)); // [R21] [R11]
	assign wr_collide = dr_wr & serial_enable_r & ~wr_ok &
		(busy_r | (~master_select_r & ~clock_sample_phase_r & ~ss_int) |
		(master_select_r & ~fifo_in_ready)); // [R25] [R11]

	// The done flag clears on a data read after a status access armed it.
	assign done_clear = dr_rd & done_arm_r; // [R20]
	// The queue drains into the data buffer only while no byte waits to be read.
	assign fifo_pop = fifo_out_valid & ~transfer_done_flag_r;
	assign fifo_flush = done_clear & ovr_pend_r; // [R24]

	// The rate divider runs only during a master transfer, so the clock idles between bytes.
	sppm_clkdiv u_clkdiv (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.run(is_master & busy_r),
		.rate(clock_rate_select_r),
		.tick_r(tick)
	);

	// Receive queue between shifter and data buffer; a flush drops the overrun bytes.
	sppm_fifo #(
		.W(`SPPM_DATA_W),
		.D(`SPPM_FIFO_DEPTH),
		.AW(`SPPM_FIFO_AW)
	) u_rx_fifo (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.flush(fifo_flush),
		.in_valid(push_valid_r),
		.in_ready(fifo_in_ready),
		.in_data(push_data_r),
		.out_valid(fifo_out_valid),
		.out_ready(~transfer_done_flag_r),
		.out_data(fifo_out_data)
	);

	// Configuration and enables; a mode fault drops both enables at once.
	always @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			clock_rate_select_r <= `SPPM_RATE_RESET;
			clock_idle_polarity_r <= 1'b0;
			clock_sample_phase_r <= 1'b0;
			serial_irq_enable_r <= 1'b0;
			master_select_r <= 1'b0; // [R26]
			serial_enable_r <= 1'b0;
			sel_sw_manage_r <= 1'b0;
			sel_sw_level_r <= 1'b0;
			csr_written_r <= 1'b0;
		end
		else
		begin
			if (csr_wr)
			begin
				sel_sw_manage_r <= csr_ssm;
				sel_sw_level_r <= csr_ssi;
				csr_written_r <= 1'b1;
			end
			if (fault)
			begin
				master_select_r <= 1'b0; // [R23]
				serial_enable_r <= 1'b0;
			end
			else if (cr_wr)
			begin
				clock_rate_select_r <= cr_rate; // [R4]
				clock_idle_polarity_r <= cr_clock_idle_polarity; // [R3]
				clock_sample_phase_r <= cr_clock_sample_phase;
				serial_irq_enable_r <= cr_serial_irq_enable;
				// Enables stay off while a fault waits, outside its clearing sequence.
				if (!mode_fault_flag_r || mode_fault_flag_arm_r)
				begin
					master_select_r <= cr_master_select & csr_written_r; // [R13] [R12] [R22]
					serial_enable_r <= cr_spe;
				end
			end
		end
	end

	// Status flags; in every flag a hardware set wins over a software clear.
	always @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			transfer_done_flag_r <= 1'b0;
			mode_fault_flag_r <= 1'b0;
			overrun_flag_r <= 1'b0;
			write_collision_flag_r <= 1'b0;
			done_arm_r <= 1'b0;
			mode_fault_flag_arm_r <= 1'b0;
			write_collision_flag_arm_r <= 1'b0;
			ovr_pend_r <= 1'b0;
			rx_data_r <= 8'h00;
		end
		else
		begin
			// A status access while the done flag stands arms its clear; the arm drops with it.
			if ((csr_rd || csr_wr) && transfer_done_flag_r)
				done_arm_r <= 1'b1;
			else if (done_clear || !transfer_done_flag_r)
				done_arm_r <= 1'b0;
			// A byte leaving the queue sets the done flag and lands in the data buffer.
			if (fifo_pop)
			begin
				transfer_done_flag_r <= 1'b1; // [R18]
				rx_data_r <= fifo_out_data;
			end
			else if (done_clear)
				transfer_done_flag_r <= 1'b0; // [R20]
			// A byte completing while the done flag stands is an overrun.
			if (push_valid_r && transfer_done_flag_r)
			begin
				overrun_flag_r <= 1'b1; // [R24]
				ovr_pend_r <= 1'b1;
			end
			else
			begin
				if (csr_rd)
					overrun_flag_r <= 1'b0;
				if (fifo_flush)
					ovr_pend_r <= 1'b0;
			end
			// Fault clear: a status read while set, then a control write.
			if (csr_rd && mode_fault_flag_r)
				mode_fault_flag_arm_r <= 1'b1;
			else if (cr_wr)
				mode_fault_flag_arm_r <= 1'b0;
			if (fault)
				mode_fault_flag_r <= 1'b1; // [R23]
			else if (cr_wr && mode_fault_flag_arm_r)
				mode_fault_flag_r <= 1'b0;
			// Collision clear: a status read while set, then a data read.
			if (csr_rd && write_collision_flag_r)
				write_collision_flag_arm_r <= 1'b1;
			else if (dr_rd)
				write_collision_flag_arm_r <= 1'b0;
			if (wr_collide)
				write_collision_flag_r <= 1'b1; // [R25]
			else if (dr_rd && write_collision_flag_arm_r)
				write_collision_flag_r <= 1'b0;
		end
	end

	// Shift engine shared by both modes; counts sixteen clock edges per byte.
	always @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			busy_r <= 1'b0; // [R26]
			shift_r <= 8'h00;
			samp_r <= 1'b0;
			edge_cnt_r <= 4'h0;
			sck_out_r <= 1'b0;
			push_valid_r <= 1'b0;
			push_data_r <= 8'h00;
		end
		else
		begin
			push_valid_r <= 1'b0;
			if (!is_master)
				sck_out_r <= clock_idle_polarity_r;
			// Disable, fault or a slave deselect abandons the byte in flight.
			if (!serial_enable_r || fault || (busy_r && !master_select_r && ss_int))
			begin
				busy_r <= 1'b0; // [R10] [R11]
				edge_cnt_r <= 4'h0;
			end
			// An accepted data write loads the shifter; only a master starts at once.
			else if (dr_wr && wr_ok)
			begin
				shift_r <= dr_wdata; // [R14] [R16]
				edge_cnt_r <= 4'h0;
				busy_r <= master_select_r; // [R14]
				sck_out_r <= clock_idle_polarity_r;
			end
			// Each serial clock edge samples the input bit or shifts the register, except the first edge with phase one, which does neither.
			else if (ev)
			begin
				busy_r <= ~last_edge; // [R17]
				edge_cnt_r <= edge_cnt_r + 4'h1;
				if (is_master)
					sck_out_r <= ~sck_out_r; // [R4]
				if (sample_edge && !last_edge)
					samp_r <= in_bit;
				else if (!(clock_sample_phase_r && edge_cnt_r == 4'h0))
					shift_r <= rx_byte; // [R15] [R16]
				if (last_edge)
				begin
					push_valid_r <= 1'b1; // [R18]
					push_data_r <= rx_byte;
				end
			end
		end
	end

	// Pin drivers, enables and interrupt request, all registered.
	always @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sck_oe_r <= 1'b0;
			mosi_oe_r <= 1'b0;
			miso_oe_r <= 1'b0;
			mosi_out_r <= 1'b0;
			miso_out_r <= 1'b0;
			irq_req_r <= 1'b0;
		end
		else
		begin
			sck_oe_r <= is_master & ~fault; // [R1]
			mosi_oe_r <= is_master & ~fault;
			miso_oe_r <= slave_sel;
			mosi_out_r <= shift_r[7]; // [R15]
			miso_out_r <= shift_r[7]; // [R16]
			// Collisions never raise the request; the mask gates all other causes.
			irq_req_r <= serial_irq_enable_r & ~cpu_irq_mask &
				(transfer_done_flag_r | mode_fault_flag_r | overrun_flag_r); // [R19] [R23]
		end
	end
endmodule // sppm_top

// ==== include/sppm_defs.vh ====
// Constants for the byte-wide serial port: widths, clock rate table, depths.
// Assumes it is included by bare name from every design file of the port.
// Notes on behaviour
// [R1] Master alone starts transfers, drives the clock.
// [R2] Every byte shifts out and in together.
// [R3] Partner uses the same polarity and phase.
// [R4] Master drives clock, 3-bit rate select field.
// [R5] Six rates, fastest one quarter of clock.
// [R6] Slave takes clock from pin, half rate max.
// [R7] Software select source follows level bit.
// [R8] Software select ignores the select pin.
// [R9] Master needs internal select high to stay.
// [R10] Phase-one slave: select low whole transmission.
// [R11] Phase-zero slave: low select write collides.
// [R12] Software sets rate, select, then enables master.
// [R13] Master bit dropped without earlier status write.
// [R14] Master data write loads shifter, starts transfer.
// [R15] Master shifts out most significant bit first.
// [R16] Slave data write loads shifter, MSB first.
// [R17] Slave starts on first master clock edge.
// [R18] Completed byte sets the done flag.
// [R19] Done interrupt needs enable and clear mask.
// [R20] Done clears: status access, then data read.
// [R21] Data writes ignored while done pending; the code accepts one once a status access has armed the clear.
// [R22] Software sets slave mode by clearing master.
// [R23] Master select low: fault, disable, interrupt.
// [R24] Second byte while pending sets overrun flag.
// [R25] Write during transfer discarded, collision flag.
// [R26] Reset leaves port disabled slave, flags clear.
`ifndef SPPM_DEFS_VH
`define SPPM_DEFS_VH
`define SPPM_DATA_W 8
`define SPPM_FIFO_DEPTH 16
`define SPPM_FIFO_AW 4
`define SPPM_EDGE_LAST 4'hf
`define SPPM_HALF_W 7
`define SPPM_HALF_R0 7'h02
`define SPPM_HALF_R1 7'h04
`define SPPM_HALF_R2 7'h08
`define SPPM_HALF_R3 7'h10
`define SPPM_HALF_R4 7'h20
`define SPPM_HALF_R5 7'h40
`define SPPM_RATE_RESET 3'h0
`endif

// ==== rtl/sppm_fifo.v ====
// Synchronous FIFO with valid/ready on both sides and a flush input.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/100ps
`include "sppm_defs.vh"
module sppm_fifo #(
	parameter W = 8,
	parameter D = 16,
	parameter AW = 4
)(
	input wire clk_sys,
	input wire reset_n,
	input wire flush,
	input wire in_valid,
	output wire in_ready,
	input wire [W-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [W-1:0] out_data
);
	reg [W-1:0] mem_r [0:D-1];
	reg [AW-1:0] wr_ptr_r;
	reg [AW-1:0] rd_ptr_r;
	reg [AW:0] count_r;
	wire push;
	wire pop;
	genvar gi;

	// Full and empty come straight from the fill count.
	assign in_ready = (count_r != D[AW:0]);
	assign out_valid = (count_r != {(AW+1){1'b0}});
	assign out_data = mem_r[rd_ptr_r];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// Pointers and count; flush empties the queue and wins over a push.
	always @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			wr_ptr_r <= {AW{1'b0}};
			rd_ptr_r <= {AW{1'b0}};
			count_r <= {(AW+1){1'b0}};
		end
		else if (flush)
		begin
			wr_ptr_r <= {AW{1'b0}};
			rd_ptr_r <= {AW{1'b0}};
			count_r <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wr_ptr_r <= wr_ptr_r + 1'b1;
			if (pop)
				rd_ptr_r <= rd_ptr_r + 1'b1;
			if (push && !pop)
				count_r <= count_r + 1'b1;
			else if (pop && !push)
				count_r <= count_r - 1'b1;
		end
	end

	// One storage word per entry, written at the write pointer.
	generate
		for (gi = 0; gi < D; gi = gi + 1)
		begin : g_word
			always @(posedge clk_sys or negedge reset_n)
			begin
				if (!reset_n)
					mem_r[gi] <= {W{1'b0}};
				else if (push && !flush && (wr_ptr_r == gi[AW-1:0]))
					mem_r[gi] <= in_data;
			end
		end
	endgenerate
endmodule // sppm_fifo

// ==== rtl/sppm_clkdiv.v ====
// Serial clock divider: one-cycle tick every half period of the chosen rate.
// Assumes run is held high for the whole of a master transfer.
`timescale 1ns/100ps
`include "sppm_defs.vh"
module sppm_clkdiv (
	input wire clk_sys,
	input wire reset_n,
	input wire run,
	input wire [2:0] rate,
	output reg tick_r
);
	reg [`SPPM_HALF_W-1:0] cnt_r;
	reg [`SPPM_HALF_W-1:0] half;

	// Six half periods; unused codes fall back to the slowest rate.
	always @*
	begin
		case (rate)
			3'h0: half = `SPPM_HALF_R0; // [R5]
			3'h1: half = `SPPM_HALF_R1;
			3'h2: half = `SPPM_HALF_R2;
			3'h3: half = `SPPM_HALF_R3;
			3'h4: half = `SPPM_HALF_R4;
			default: half = `SPPM_HALF_R5;
		endcase
	end

	// Counts while running and pulses at the end of each half period.
	always @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cnt_r <= {`SPPM_HALF_W{1'b0}};
			tick_r <= 1'b0;
		end
		else if (!run)
		begin
			cnt_r <= {`SPPM_HALF_W{1'b0}};
			tick_r <= 1'b0;
		end
		else if (cnt_r == half - 1'b1)
		begin
			cnt_r <= {`SPPM_HALF_W{1'b0}};
			tick_r <= 1'b1; // [R4]
		end
		else
		begin
			cnt_r <= cnt_r + 1'b1;
			tick_r <= 1'b0;
		end
	end
endmodule // sppm_clkdiv

// ==== dv/sppm_props.sv ====
// Port checks for the serial port, bound into the top module.
// Assumes one clock, strobes of one cycle and reset_n active low.
`timescale 1ns/100ps
module sppm_props (
	input wire clk_sys,
	input wire reset_n,
	input wire dr_wr,
	input wire [7:0] dr_wdata,
	input wire dr_rd,
	input wire csr_rd,
	input wire cpu_irq_mask,
	input wire transfer_done_flag_r,
	input wire mode_fault_flag_r,
	input wire overrun_flag_r,
	input wire write_collision_flag_r,
	input wire master_select_r,
	input wire serial_enable_r,
	input wire busy_r,
	input wire irq_req_r,
	input wire mosi_out_r
);
	reg [11:0] len_r;
	// Counts the cycles of the running transfer to bound its rate.
	always @(posedge clk_sys or negedge reset_n)
		if (!reset_n)
			len_r <= 12'h000;
		else
			len_r <= busy_r ? len_r + 12'h001 : 12'h000;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// An accepted master write.
	sequence s_start;
		dr_wr && serial_enable_r && master_select_r && !busy_r && !transfer_done_flag_r;
	endsequence
	// A master byte that ends while nothing is pending.
	sequence s_end;
		$fell(busy_r) && master_select_r && !transfer_done_flag_r;
	endsequence
	property p_start;
		s_start |=> busy_r;
	endproperty
	a_start: assert property (p_start) else $error("no start");
	property p_msb;
		s_start |-> ##2 mosi_out_r == $past(dr_wdata[7], 2);
	endproperty
	a_msb: assert property (p_msb) else $error("first bit wrong");
	property p_done;
		s_end |-> ##[1:4] transfer_done_flag_r;
	endproperty
	a_done: assert property (p_done) else $error("done not set");
	property p_len;
		$fell(busy_r) && master_select_r |-> len_r >= 12'h01e && len_r <= 12'h410;
	endproperty
	a_len: assert property (p_len) else $error("byte length");
	property p_hold;
		transfer_done_flag_r && !dr_rd |=> transfer_done_flag_r;
	endproperty
	a_hold: assert property (p_hold) else $error("done lost");
	property p_write_collision_flag;
		dr_wr && busy_r |=> write_collision_flag_r;
	endproperty
	a_write_collision_flag: assert property (p_write_collision_flag) else $error("no collision");
	property p_mask;
		cpu_irq_mask |=> !irq_req_r;
	endproperty
	a_mask: assert property (p_mask) else $error("masked irq");
	property p_ovr;
		csr_rd && !busy_r && !$fell(busy_r) |=> !overrun_flag_r;
	endproperty
	a_ovr: assert property (p_ovr) else $error("overrun kept");
	property p_fault;
		$rose(mode_fault_flag_r) |-> !master_select_r && !serial_enable_r;
	endproperty
	a_fault: assert property (p_fault) else $error("fault left enabled");
endmodule // sppm_props
bind sppm_top sppm_props u_props (
	.clk_sys(clk_sys),
	.reset_n(reset_n),
	.dr_wr(dr_wr),
	.dr_wdata(dr_wdata),
	.dr_rd(dr_rd),
	.csr_rd(csr_rd),
	.cpu_irq_mask(cpu_irq_mask),
	.transfer_done_flag_r(transfer_done_flag_r),
	.mode_fault_flag_r(mode_fault_flag_r),
	.overrun_flag_r(overrun_flag_r),
	.write_collision_flag_r(write_collision_flag_r),
	.master_select_r(master_select_r),
	.serial_enable_r(serial_enable_r),
	.busy_r(busy_r),
	.irq_req_r(irq_req_r),
	.mosi_out_r(mosi_out_r)
);

// ==== dv/sppm_ext_slave.sv ====
// Behavioural external slave: returns a byte on miso while taking one from mosi.
// Assumes load pulses before each frame and sel_n stays low during it.
`timescale 1ns/100ps
module sppm_ext_slave (
	input wire sck,
	input wire mosi,
	input wire sel_n,
	input wire clock_idle_polarity,
	input wire clock_sample_phase,
	input wire load,
	input wire [7:0] tx_byte,
	output wire miso,
	output logic [7:0] rx_byte
);
	logic [7:0] sr = 8'h00;
	logic pend = 1'b0;
	// Loads the reply; with phase one the first edge must not shift.
	always @(posedge load)
	begin
		sr = tx_byte;
		pend = clock_sample_phase;
	end
	// Samples on the edge the mode selects and shifts on the other.
	always @(sck)
	begin
		if (!sel_n)
		begin
			if ((sck != clock_idle_polarity) ^ clock_sample_phase)
			begin
				rx_byte = {rx_byte[6:0], mosi};
				pend = 1'b0;
			end
			else if (!pend)
				sr = {sr[6:0], 1'b0};
			else
				pend = 1'b0;
		end
	end
	// A deselected slave does not leave its last bit on the line.
	assign miso = sel_n ? ~sr[7] : sr[7];
endmodule // sppm_ext_slave

// ==== dv/testbench.sv ====
// Self-checking bench: the port as master against a behavioural slave.
// Assumes the port, its checker and the slave model are compiled first.
`timescale 1ns/100ps
module testbench;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic cr_wr = 0, cr_clock_idle_polarity = 0, cr_clock_sample_phase = 0, cr_master_select = 0, cr_spe = 0, cr_serial_irq_enable = 0;
	logic [2:0] cr_rate = 3'h0;
	logic csr_wr = 0, csr_ssm = 0, csr_ssi = 0, csr_rd = 0, dr_wr = 0, dr_rd = 0;
	logic cpu_irq_mask = 0, ss_n_in = 1, sel_n = 1, load = 0;
	logic [7:0] dr_wdata = 8'h00, ext_tx = 8'h00, b0, p0;
	logic [2:0] r;
	wire [7:0] rx_data_r, ext_rx;
	wire transfer_done_flag_r, mode_fault_flag_r, overrun_flag_r, write_collision_flag_r;
	wire master_select_r, serial_enable_r, busy_r, irq_req_r, miso;
	wire sck_out_r, sck_oe_r, mosi_out_r, mosi_oe_r, miso_out_r, miso_oe_r;
	int fail_count = 0;
	int comparisons = 0;
	int seed = 32'ha4d0e8b6;
	int i;
	int k;
	sppm_top uut (.*, .sck_in(sck_out_r), .mosi_in(mosi_out_r), .miso_in(miso));
	sppm_ext_slave u_ext (.sck(sck_out_r), .mosi(mosi_out_r), .sel_n(sel_n), .clock_idle_polarity(cr_clock_idle_polarity),
		.clock_sample_phase(cr_clock_sample_phase), .load(load), .tx_byte(ext_tx), .miso(miso), .rx_byte(ext_rx));
	// Clock of 50 ns.
	always #25 clk_sys = ~clk_sys;
	// Compares and counts.
	task automatic chk(string n, logic [7:0] e, logic [7:0] s);
		comparisons++;
		if (s !== e)
		begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	// One-cycle strobe.
	task automatic pulse(ref logic s);
		@(negedge clk_sys) s = 1'b1;
		@(negedge clk_sys) s = 1'b0;
	endtask
	// Control write; the interrupt enable is always on.
	task automatic ctrl(logic [2:0] rt, logic pl, logic ph, logic m, logic e);
		@(negedge clk_sys);
		{cr_rate, cr_clock_idle_polarity, cr_clock_sample_phase, cr_master_select, cr_spe, cr_serial_irq_enable, cr_wr} = {rt, pl, ph, m, e, 2'b11};
		@(negedge clk_sys) cr_wr = 1'b0;
	endtask
	// Select handling write.
	task automatic csw(logic m, logic l);
		@(negedge clk_sys);
		{csr_ssm, csr_ssi, csr_wr} = {m, l, 1'b1};
		@(negedge clk_sys) csr_wr = 1'b0;
	endtask
	// Data write.
	task automatic send(logic [7:0] d);
		@(negedge clk_sys);
		{dr_wdata, dr_wr} = {d, 1'b1};
		@(negedge clk_sys) dr_wr = 1'b0;
	endtask
	// Bounded wait for the done or overrun flag.
	task automatic wait_flag(logic overrun_flag);
		for (k = 0; k < 5000 && (overrun_flag ? overrun_flag_r : transfer_done_flag_r) !== 1'b1; k++)
			@(negedge clk_sys);
	endtask
	// Interrupt expected from the mask with the enable set.
	function automatic logic [7:0] irq_exp(logic m);
		return {7'h00, ~m};
	endfunction
	// Prints the verdict and stops.
	task automatic end_sim;
		if (fail_count == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Cuts a hang short.
	initial
	begin
		#3000000;
		fail_count++;
		end_sim;
	end
	// Main sequence.
	initial
	begin
		repeat (3) @(negedge clk_sys);
		reset_n = 1'b1;
		chk("state", 8'h00, {master_select_r, serial_enable_r, busy_r, transfer_done_flag_r,
			mode_fault_flag_r, overrun_flag_r, write_collision_flag_r, irq_req_r});
		send(8'h5a);
		chk("busy", 8'h00, {7'h00, busy_r});
		ctrl(3'h1, 1'b0, 1'b0, 1'b0, 1'b0);
		csw(1'b1, 1'b1);
		ctrl(3'h1, 1'b0, 1'b0, 1'b1, 1'b1);
		chk("enables", 8'h03, {6'h00, master_select_r, serial_enable_r});
		for (i = 0; i < 12; i++)
		begin
			b0 = 8'($random(seed));
			p0 = 8'($random(seed));
			r = 3'h1 + 3'($unsigned($random(seed)) % 5);
			ctrl(r, i[1], i[0], 1'b1, 1'b0);
			ctrl(r, i[1], i[0], 1'b1, 1'b1);
			ext_tx = p0;
			pulse(load);
			sel_n = 1'b0;
			cpu_irq_mask = b0[0];
			ss_n_in = p0[1];
			send(b0);
			if (i == 0)
			begin
				send(~b0);
				chk("collision", 8'h01, {7'h00, write_collision_flag_r});
			end
			wait_flag(1'b0);
			chk("rx byte", p0, rx_data_r);
			chk("slave byte", b0, ext_rx);
			chk("oe", 8'h06, {5'h00, sck_oe_r, mosi_oe_r, miso_oe_r});
			repeat (2) @(negedge clk_sys);
			chk("irq", irq_exp(b0[0]), {7'h00, irq_req_r});
			sel_n = 1'b1;
			if (i == 1)
			begin
				pulse(dr_rd);
				chk("done kept", 8'h01, {7'h00, transfer_done_flag_r});
			end
			pulse(csr_rd);
			pulse(dr_rd);
			chk("cleared", 8'h00, {6'h00, transfer_done_flag_r, write_collision_flag_r});
		end
		ss_n_in = 1'b1;
		ext_tx = 8'h3c;
		pulse(load);
		sel_n = 1'b0;
		send(8'hc3);
		wait_flag(1'b0);
		send(8'h99);
		chk("inhibit", 8'h00, {7'h00, busy_r});
		sel_n = 1'b1;
		ext_tx = 8'h66;
		pulse(load);
		sel_n = 1'b0;
		pulse(csr_rd);
		send(8'h99);
		wait_flag(1'b1);
		chk("overrun", 8'h01, {7'h00, overrun_flag_r});
		chk("kept byte", 8'h3c, rx_data_r);
		pulse(csr_rd);
		chk("overrun clr", 8'h00, {7'h00, overrun_flag_r});
		pulse(dr_rd);
		sel_n = 1'b1;
		csw(1'b0, 1'b1);
		ss_n_in = 1'b0;
		for (k = 0; k < 20 && mode_fault_flag_r !== 1'b1; k++)
			@(negedge clk_sys);
		chk("fault", 8'h04, {5'h00, mode_fault_flag_r, master_select_r, serial_enable_r});
		chk("oe off", 8'h00, {5'h00, sck_oe_r, mosi_oe_r, miso_oe_r});
		ss_n_in = 1'b1;
		repeat (4) @(negedge clk_sys);
		pulse(csr_rd);
		ctrl(3'h0, 1'b0, 1'b0, 1'b1, 1'b1);
		chk("restored", 8'h03, {5'h00, mode_fault_flag_r, master_select_r, serial_enable_r});
		end_sim;
	end
endmodule // testbench
